//--- design/tpwm_decoder.sv
// Purpose: Decode host PWM and GPIO levels into six gate commands.
// Assumes: Single mclk domain, rst_n synchronous and active low.
// Notes: Inputs pass a two-stage synchroniser; gates are registered.
// How it works
// R1 - Six-input: high only on 10, low on 01
// R2 - Three-input: high input drives complementary gates
// R3 - Three-input: low-side inputs are ignored
// R4 - Single-PWM: A-high modulates, four pins select
// R5 - Any duty, including continuous high, is accepted
// R6 - Single-PWM uses the live configuration settings
// R7 - Dwell held by phase C high input
// R8 - Single-PWM ignores phase C low input
// R9 - Freewheel table chosen by configuration input
// R10 - Index order aLo bHi bLo cHi; AB CB CA
// R11 - BA BC AC drive sourcing PWM, sink low
// R12 - Overlap codes ending 1 merge adjacent steps
// R13 - 1110 aligns, 0000 turns everything off
// R14 - Diode table holds PWM phase low off
// R15 - Interlock keeps phase switches never both on
// R16 - All inputs synchronised before decoding
// R17 - Mode from configuration, resets to six-input
`timescale 1ns/1ns
module tpwm_decoder (
    input wire logic mclk, // 25 MHz logic clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic phase_a_high_input, // A high input, PWM in 1-PWM
    input wire logic phase_a_low_input, // A low input, select bit 3
    input wire logic phase_b_high_input, // B high input, select bit 2
    input wire logic phase_b_low_input, // B low input, select bit 1
    input wire logic phase_c_high_input, // C high input, dwell hold
    input wire logic phase_c_low_input, // C low input
    input wire logic [1:0] mode_select, // Scheme setting
    input wire logic diode_freewheel, // 1 selects diode table
    output logic phase_a_high_gate, // A high gate command
    output logic phase_a_low_gate, // A low gate command
    output logic phase_b_high_gate, // B high gate command
    output logic phase_b_low_gate, // B low gate command
    output logic phase_c_high_gate, // C high gate command
    output logic phase_c_low_gate // C low gate command
);

    // Synchroniser stages; stage one feeds stage two only
    logic [tpwm_pkg::IN_W-1:0] in_meta_r;
    logic [tpwm_pkg::IN_W-1:0] in_meta_nxt;
    logic [tpwm_pkg::IN_W-1:0] in_r;
    logic [tpwm_pkg::IN_W-1:0] in_nxt;
    logic [1:0] mode_meta_r;
    logic [1:0] mode_meta_nxt;
    tpwm_pkg::tpwm_mode_type mode_r;
    tpwm_pkg::tpwm_mode_type mode_nxt;
    logic diode_meta_r;
    logic diode_meta_nxt;
    logic diode_r;
    logic diode_nxt;

    // Decoded gate requests and table terms
    logic [2:0] req_hi;
    logic [2:0] req_lo;
    logic [3:0] code;
    logic pwm;
    tpwm_pkg::tpwm_drive_type drv_a;
    tpwm_pkg::tpwm_drive_type drv_b;
    tpwm_pkg::tpwm_drive_type drv_c;
    logic [1:0] gates_a;
    logic [1:0] gates_b;
    logic [1:0] gates_c;

    // High and low gate pair for one phase in single-PWM mode
    function automatic logic [1:0] phase_pair(
        input tpwm_pkg::tpwm_drive_type drv,
        input logic pwm_in,
        input logic diode
    );
        logic [1:0] pair;
        pair = 2'h0;
        case (drv)
            tpwm_pkg::TPWM_DRV_PWM: begin
                pair = {pwm_in, ~pwm_in & ~diode}; // R14
            end
            tpwm_pkg::TPWM_DRV_LOW_ON: begin
                pair = 2'h1;
            end
            default: begin
                pair = 2'h0;
            end
        endcase
        return pair;
    endfunction : phase_pair

    // Next values of the synchroniser stages
    always_comb begin
        in_meta_nxt = {phase_a_high_input, phase_a_low_input,
                       phase_b_high_input, phase_b_low_input,
                       phase_c_high_input, phase_c_low_input}; // R16
        in_nxt = in_meta_r; // R16
        mode_meta_nxt = mode_select;
        mode_nxt = tpwm_pkg::tpwm_mode_type'(mode_meta_r); // R17
        diode_meta_nxt = diode_freewheel;
        diode_nxt = diode_meta_r; // R9
    end

    // Synchroniser registers, mode resets to six-input
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            in_meta_r <= tpwm_pkg::IN_RST;
            in_r <= tpwm_pkg::IN_RST;
            mode_meta_r <= tpwm_pkg::MODE_RST;
            mode_r <= tpwm_pkg::TPWM_MODE_SIX; // R17
            diode_meta_r <= tpwm_pkg::DIODE_RST;
            diode_r <= tpwm_pkg::DIODE_RST;
        end else begin
            in_meta_r <= in_meta_nxt;
            in_r <= in_nxt;
            mode_meta_r <= mode_meta_nxt;
            mode_r <= mode_nxt;
            diode_meta_r <= diode_meta_nxt;
            diode_r <= diode_nxt;
        end
    end

    // Single-PWM index; phase C low never enters it
    assign code = {in_r[tpwm_pkg::IN_A_LO], in_r[tpwm_pkg::IN_B_HI],
                   in_r[tpwm_pkg::IN_B_LO], in_r[tpwm_pkg::IN_C_HI]}; // R10
    assign pwm = in_r[tpwm_pkg::IN_A_HI]; // R4 R5

    // Commutation table: phase drives per state code
    always_comb begin
        drv_a = tpwm_pkg::TPWM_DRV_OFF;
        drv_b = tpwm_pkg::TPWM_DRV_OFF;
        drv_c = tpwm_pkg::TPWM_DRV_OFF;
        case (code)
            tpwm_pkg::CODE_AB: begin // R10
                drv_a = tpwm_pkg::TPWM_DRV_PWM;
                drv_b = tpwm_pkg::TPWM_DRV_LOW_ON;
            end
            tpwm_pkg::CODE_AB_CB: begin // R7 R12
                drv_a = tpwm_pkg::TPWM_DRV_PWM;
                drv_b = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_c = tpwm_pkg::TPWM_DRV_PWM;
            end
            tpwm_pkg::CODE_CB: begin // R10
                drv_b = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_c = tpwm_pkg::TPWM_DRV_PWM;
            end
            tpwm_pkg::CODE_CB_CA: begin // R12
                drv_a = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_b = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_c = tpwm_pkg::TPWM_DRV_PWM;
            end
            tpwm_pkg::CODE_CA: begin // R10
                drv_a = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_c = tpwm_pkg::TPWM_DRV_PWM;
            end
            tpwm_pkg::CODE_CA_BA: begin // R12
                drv_a = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_b = tpwm_pkg::TPWM_DRV_PWM;
                drv_c = tpwm_pkg::TPWM_DRV_PWM;
            end
            tpwm_pkg::CODE_BA: begin // R11
                drv_a = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_b = tpwm_pkg::TPWM_DRV_PWM;
            end
            tpwm_pkg::CODE_BA_BC: begin // R12
                drv_a = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_b = tpwm_pkg::TPWM_DRV_PWM;
                drv_c = tpwm_pkg::TPWM_DRV_LOW_ON;
            end
            tpwm_pkg::CODE_BC: begin // R11
                drv_b = tpwm_pkg::TPWM_DRV_PWM;
                drv_c = tpwm_pkg::TPWM_DRV_LOW_ON;
            end
            tpwm_pkg::CODE_BC_AC: begin // R12
                drv_a = tpwm_pkg::TPWM_DRV_PWM;
                drv_b = tpwm_pkg::TPWM_DRV_PWM;
                drv_c = tpwm_pkg::TPWM_DRV_LOW_ON;
            end
            tpwm_pkg::CODE_AC: begin // R11
                drv_a = tpwm_pkg::TPWM_DRV_PWM;
                drv_c = tpwm_pkg::TPWM_DRV_LOW_ON;
            end
            tpwm_pkg::CODE_AC_AB, tpwm_pkg::CODE_ALIGN: begin // R12 R13
                drv_a = tpwm_pkg::TPWM_DRV_PWM;
                drv_b = tpwm_pkg::TPWM_DRV_LOW_ON;
                drv_c = tpwm_pkg::TPWM_DRV_LOW_ON;
            end
            default: begin // R13
                drv_a = tpwm_pkg::TPWM_DRV_OFF;
            end
        endcase
    end

    // Gate pairs follow the live freewheel setting
    assign gates_a = phase_pair(drv_a, pwm, diode_r); // R6 R9
    assign gates_b = phase_pair(drv_b, pwm, diode_r); // R6 R9
    assign gates_c = phase_pair(drv_c, pwm, diode_r); // R6 R9

    // Mode multiplexer for the gate requests
    always_comb begin
        req_hi = 3'h0;
        req_lo = 3'h0;
        case (mode_r)
            tpwm_pkg::TPWM_MODE_SIX: begin
                req_hi = {in_r[tpwm_pkg::IN_A_HI], in_r[tpwm_pkg::IN_B_HI],
                          in_r[tpwm_pkg::IN_C_HI]}
                         & ~{in_r[tpwm_pkg::IN_A_LO], in_r[tpwm_pkg::IN_B_LO],
                             in_r[tpwm_pkg::IN_C_LO]}; // R1
                req_lo = ~{in_r[tpwm_pkg::IN_A_HI], in_r[tpwm_pkg::IN_B_HI],
                           in_r[tpwm_pkg::IN_C_HI]}
                         & {in_r[tpwm_pkg::IN_A_LO], in_r[tpwm_pkg::IN_B_LO],
                            in_r[tpwm_pkg::IN_C_LO]}; // R1
            end
            tpwm_pkg::TPWM_MODE_THREE: begin
                req_hi = {in_r[tpwm_pkg::IN_A_HI], in_r[tpwm_pkg::IN_B_HI],
                          in_r[tpwm_pkg::IN_C_HI]}; // R2 R3
                req_lo = ~req_hi; // R2 R3
            end
            tpwm_pkg::TPWM_MODE_SINGLE: begin
                req_hi = {gates_a[1], gates_b[1], gates_c[1]}; // R4 R8
                req_lo = {gates_a[0], gates_b[0], gates_c[0]}; // R4 R8
            end
            default: begin
                req_hi = 3'h0;
                req_lo = 3'h0;
            end
        endcase
    end

    // One interlock per phase, A is bit 2
    tpwm_phase_interlock u_lock_a (
        .mclk(mclk),
        .rst_n(rst_n),
        .req_hi(req_hi[2]),
        .req_lo(req_lo[2]),
        .gate_hi(phase_a_high_gate),
        .gate_lo(phase_a_low_gate)
    );
    tpwm_phase_interlock u_lock_b (
        .mclk(mclk),
        .rst_n(rst_n),
        .req_hi(req_hi[1]),
        .req_lo(req_lo[1]),
        .gate_hi(phase_b_high_gate),
        .gate_lo(phase_b_low_gate)
    );
    tpwm_phase_interlock u_lock_c (
        .mclk(mclk),
        .rst_n(rst_n),
        .req_hi(req_hi[0]),
        .req_lo(req_lo[0]),
        .gate_hi(phase_c_high_gate),
        .gate_lo(phase_c_low_gate)
    );

    // Six-input: 10 held two cycles gives high gate only
    property p_six_high;
        @(posedge mclk) disable iff (!rst_n)
        (mode_r == tpwm_pkg::TPWM_MODE_SIX && in_r[tpwm_pkg::IN_A_HI]
         && !in_r[tpwm_pkg::IN_A_LO])[*2]
        |=> phase_a_high_gate && !phase_a_low_gate;
    endproperty
    a_six_high: assert property (p_six_high) // R1
        else $error("six-input 10 did not drive high gate");

    // Six-input: equal inputs turn both gates off
    property p_six_equal;
        @(posedge mclk) disable iff (!rst_n)
        mode_r == tpwm_pkg::TPWM_MODE_SIX
        && in_r[tpwm_pkg::IN_B_HI] == in_r[tpwm_pkg::IN_B_LO]
        |=> !phase_b_high_gate && !phase_b_low_gate;
    endproperty
    a_six_equal: assert property (p_six_equal) // R1
        else $error("six-input equal inputs left a gate on");

    // Three-input: high input low for two cycles gives low gate
    property p_three_low;
        @(posedge mclk) disable iff (!rst_n)
        (mode_r == tpwm_pkg::TPWM_MODE_THREE
         && !in_r[tpwm_pkg::IN_C_HI])[*2]
        |=> phase_c_low_gate && !phase_c_high_gate;
    endproperty
    a_three_low: assert property (p_three_low) // R2
        else $error("three-input complement missing");

    // Three-input: low-side pin alone never moves a request
    property p_three_ignore;
        @(posedge mclk) disable iff (!rst_n)
        mode_r == tpwm_pkg::TPWM_MODE_THREE && $stable(mode_r)
        && $stable(in_r[tpwm_pkg::IN_A_HI]) |-> $stable(req_lo[2]);
    endproperty
    a_three_ignore: assert property (p_three_ignore) // R3
        else $error("three-input reacted to low-side pin");

    // Single-PWM: phase C low pin has no effect
    property p_single_ignore_c;
        @(posedge mclk) disable iff (!rst_n)
        mode_r == tpwm_pkg::TPWM_MODE_SINGLE && $stable(mode_r)
        && $stable(diode_r)
        && $stable(in_r[tpwm_pkg::IN_A_HI:tpwm_pkg::IN_C_HI])
        |-> $stable(req_hi) && $stable(req_lo);
    endproperty
    a_single_ignore_c: assert property (p_single_ignore_c) // R8
        else $error("single-PWM reacted to phase C low pin");

    // Active AB with PWM high: A high, B low on, C off
    property p_active_ab;
        @(posedge mclk) disable iff (!rst_n)
        (mode_r == tpwm_pkg::TPWM_MODE_SINGLE && !diode_r
         && code == tpwm_pkg::CODE_AB && pwm)[*2]
        |=> phase_a_high_gate && phase_b_low_gate
            && !phase_c_high_gate && !phase_c_low_gate;
    endproperty
    a_active_ab: assert property (p_active_ab) // R10
        else $error("AB state wrong in active table");

    // Diode table keeps the PWM phase low switch off
    property p_diode_low_off;
        @(posedge mclk) disable iff (!rst_n)
        (mode_r == tpwm_pkg::TPWM_MODE_SINGLE && diode_r
         && code == tpwm_pkg::CODE_CA_BA)[*2]
        |=> !phase_b_low_gate && !phase_c_low_gate && phase_a_low_gate;
    endproperty
    a_diode_low_off: assert property (p_diode_low_off) // R14
        else $error("diode table drove low of PWM phase");

    // Stop code turns all six gates off
    property p_stop;
        @(posedge mclk) disable iff (!rst_n)
        mode_r == tpwm_pkg::TPWM_MODE_SINGLE && code == tpwm_pkg::CODE_STOP
        |=> !(phase_a_high_gate || phase_a_low_gate || phase_b_high_gate
              || phase_b_low_gate || phase_c_high_gate || phase_c_low_gate);
    endproperty
    a_stop: assert property (p_stop) // R13
        else $error("stop code left a gate on");

    // Mode register shows six-input after reset
    property p_mode_reset;
        @(posedge mclk)
        !$past(rst_n) |-> mode_r == tpwm_pkg::TPWM_MODE_SIX;
    endproperty
    a_mode_reset: assert property (p_mode_reset) // R17
        else $error("mode not six-input after reset");

endmodule : tpwm_decoder

//--- design/tpwm_phase_interlock.sv
// Purpose: Break-before-make interlock for the two gates of one phase.
// Assumes: Requests are already synchronous to mclk.
// Notes: A gate turns on only one cycle after its partner is seen off.
`timescale 1ns/1ns
module tpwm_phase_interlock (
    input wire logic mclk, // Logic clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic req_hi, // Requested high gate level
    input wire logic req_lo, // Requested low gate level
    output logic gate_hi, // High gate command, registered
    output logic gate_lo // Low gate command, registered
);

    logic hi_r;
    logic lo_r;
    logic hi_nxt;
    logic lo_nxt;

    // Grant a gate only when its partner is off now and not requested
    always_comb begin
        hi_nxt = req_hi & ~req_lo & ~lo_r; // R15
        lo_nxt = req_lo & ~req_hi & ~hi_r; // R15
    end

    // Gate registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hi_r <= 1'b0;
            lo_r <= 1'b0;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    assign gate_hi = hi_r;
    assign gate_lo = lo_r;

    // Both gates never on together
    property p_never_both;
        @(posedge mclk) disable iff (!rst_n)
        !(hi_r && lo_r);
    endproperty
    a_never_both: assert property (p_never_both) // R15
        else $error("both gates of a phase on");

    // Swapping sides leaves one full cycle with both gates off
    property p_gap_on_swap;
        @(posedge mclk) disable iff (!rst_n)
        (hi_r && !req_hi && req_lo) ##1 (req_lo && !req_hi)
        |-> (!hi_r && !lo_r) ##1 lo_r;
    endproperty
    a_gap_on_swap: assert property (p_gap_on_swap) // R15
        else $error("no dead cycle on high to low swap");

endmodule : tpwm_phase_interlock

//--- design/tpwm_pkg.sv
// Purpose: Shared types and constants of the PWM commutation decoder.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Bit positions refer to the packed vector of the six gate inputs.
package tpwm_pkg;

    // Operating schemes, chosen by the mode strap inputs
    typedef enum logic [1:0] {
        TPWM_MODE_SIX,
        TPWM_MODE_THREE,
        TPWM_MODE_SINGLE,
        TPWM_MODE_RSVD
    } tpwm_mode_type;

    // Drive of one phase inside the single-PWM table
    typedef enum logic [1:0] {
        TPWM_DRV_OFF,
        TPWM_DRV_PWM,
        TPWM_DRV_LOW_ON
    } tpwm_drive_type;

    // Positions in the packed input vector
    localparam int unsigned IN_A_HI = 5;
    localparam int unsigned IN_A_LO = 4;
    localparam int unsigned IN_B_HI = 3;
    localparam int unsigned IN_B_LO = 2;
    localparam int unsigned IN_C_HI = 1;
    localparam int unsigned IN_C_LO = 0;
    localparam int unsigned IN_W = 6;

    // Reset values
    localparam logic [5:0] IN_RST = 6'h00;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic DIODE_RST = 1'b0;

    // Commutation state index codes, {a_lo, b_hi, b_lo, c_hi}
    localparam logic [3:0] CODE_AB = 4'h6;
    localparam logic [3:0] CODE_AB_CB = 4'h5;
    localparam logic [3:0] CODE_CB = 4'h4;
    localparam logic [3:0] CODE_CB_CA = 4'hd;
    localparam logic [3:0] CODE_CA = 4'hc;
    localparam logic [3:0] CODE_CA_BA = 4'h9;
    localparam logic [3:0] CODE_BA = 4'h8;
    localparam logic [3:0] CODE_BA_BC = 4'hb;
    localparam logic [3:0] CODE_BC = 4'ha;
    localparam logic [3:0] CODE_BC_AC = 4'h3;
    localparam logic [3:0] CODE_AC = 4'h2;
    localparam logic [3:0] CODE_AC_AB = 4'h7;
    localparam logic [3:0] CODE_ALIGN = 4'he;
    localparam logic [3:0] CODE_STOP = 4'h0;

endpackage : tpwm_pkg

//--- tb/tpwm_decoder_bench.sv
// Purpose: Self-checking bench of the commutation decoder.
// Assumes: Gates settle four edges after a request changes.
// Notes: Gate vector runs A high down to C low, two bits per phase.
`timescale 1ns/1ns
`define CHECK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tpwm_decoder_bench;
    logic mclk;
    logic rst_n;
    logic [5:0] pins;
    logic [1:0] mode_select;
    logic diode_freewheel;
    logic [5:0] gates;
    int failures;
    int samples_checked;
    int rise_cnt;
    logic a_hi_gate_d;
    // Phase drive per index: {A, B, C}, 0 off, 1 PWM, 2 low on
    logic [5:0] drv_tbl [16] = '{6'h00, 6'h00, 6'h12, 6'h16, 6'h09,
        6'h19, 6'h18, 6'h1a, 6'h24, 6'h25, 6'h06, 6'h26, 6'h21, 6'h29,
        6'h1a, 6'h00};

    tpwm_host_model host_u (
        .mclk(mclk),
        .pins(pins)
    );

    tpwm_decoder dut_u (
        .mclk(mclk),
        .rst_n(rst_n),
        .phase_a_high_input(pins[5]),
        .phase_a_low_input(pins[4]),
        .phase_b_high_input(pins[3]),
        .phase_b_low_input(pins[2]),
        .phase_c_high_input(pins[1]),
        .phase_c_low_input(pins[0]),
        .mode_select(mode_select),
        .diode_freewheel(diode_freewheel),
        .phase_a_high_gate(gates[5]),
        .phase_a_low_gate(gates[4]),
        .phase_b_high_gate(gates[3]),
        .phase_b_low_gate(gates[2]),
        .phase_c_high_gate(gates[1]),
        .phase_c_low_gate(gates[0])
    );

    // Expected gates of the single-PWM tables
    function automatic logic [5:0] exp_gates(input logic [3:0] code,
                                             input logic p,
                                             input logic dio);
        logic [1:0] d;
        logic [5:0] g;
        g = 6'h00;
        for (int i = 0; i < 3; i++) begin
            d = drv_tbl[code][2*i +: 2];
            if (d == 2'h1) g[2*i +: 2] = {p, ~p & ~dio};
            else if (d == 2'h2) g[2*i +: 2] = 2'h1;
        end
        return g;
    endfunction : exp_gates

    // Clock source
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Both switches of a phase never on together
    always @(negedge mclk) begin
        if (rst_n) `CHECK(|(gates & (gates >> 1) & 6'h15), 1'b0)
    end

    // Count rising edges of the A high gate
    always @(posedge mclk) begin
        a_hi_gate_d <= gates[5];
        if (gates[5] === 1'b1 && a_hi_gate_d === 1'b0) begin
            rise_cnt <= rise_cnt + 1;
        end
    end

    task automatic set_cfg(input logic [1:0] m, input logic d);
        @(posedge mclk);
        mode_select <= m;
        diode_freewheel <= d;
    endtask : set_cfg

    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask : settle

    // Mid-run reset clears every gate
    task automatic t_reset();
        host_u.put(6'h2a);
        settle();
        `CHECK(gates, 6'h2a)
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        `CHECK(gates, 6'h00)
        @(posedge mclk);
        rst_n <= 1'b1;
        host_u.put(6'h00);
        settle();
        `CHECK(gates, 6'h00)
    endtask : t_reset

    // Six-input truth table over all pin patterns
    task automatic t_six();
        logic [5:0] e;
        for (int v = 0; v < 64; v++) begin
            host_u.put(v[5:0]);
            settle();
            for (int i = 0; i < 3; i++)
                e[2*i +: 2] = {v[2*i+1] & ~v[2*i], v[2*i] & ~v[2*i+1]};
            `CHECK(gates, e)
        end
    endtask : t_six

    // Latency and one dead cycle on a reversal
    task automatic t_dead();
        host_u.put(6'h20);
        settle();
        host_u.put(6'h10);
        repeat (2) @(posedge mclk);
        #1;
        `CHECK(gates, 6'h20)
        @(posedge mclk);
        #1;
        `CHECK(gates, 6'h00)
        @(posedge mclk);
        #1;
        `CHECK(gates, 6'h10)
    endtask : t_dead

    // Three-input mode, low pins toggled throughout
    task automatic t_three();
        logic [5:0] e;
        set_cfg(2'h1, 1'b0);
        for (int v = 0; v < 64; v++) begin
            host_u.put(v[5:0]);
            settle();
            for (int i = 0; i < 3; i++)
                e[2*i +: 2] = {v[2*i+1], ~v[2*i+1]};
            `CHECK(gates, e)
        end
    endtask : t_three

    // Every index at PWM held low and held high
    task automatic t_single(input logic dio);
        logic [5:0] e;
        set_cfg(2'h2, dio);
        for (int c = 0; c < 32; c++) begin
            host_u.put_code(c[3:0], c[4], c[0] ^ c[4]);
            settle();
            e = exp_gates(c[3:0], c[4], dio);
            `CHECK(gates, e)
        end
    endtask : t_single

    // PWM pulses reach the sourcing high gate one for one
    task automatic t_pwm();
        set_cfg(2'h2, 1'b0);
        host_u.put_code(4'h6, 1'b0, 1'b0);
        settle();
        rise_cnt = 0;
        host_u.burst(5, 3, 3);
        repeat (8) @(posedge mclk);
        #1;
        `CHECK(rise_cnt, 5)
    endtask : t_pwm

    // Dwell row stands while C high is held, then next step
    task automatic t_dwell();
        host_u.put_code(4'h6, 1'b1, 1'b0);
        settle();
        `CHECK(gates, exp_gates(4'h6, 1'b1, 1'b0))
        host_u.put_code(4'h5, 1'b1, 1'b1);
        settle();
        repeat (10) @(posedge mclk);
        #1;
        `CHECK(gates, exp_gates(4'h5, 1'b1, 1'b0))
        host_u.put_code(4'h4, 1'b1, 1'b0);
        settle();
        `CHECK(gates, exp_gates(4'h4, 1'b1, 1'b0))
    endtask : t_dwell

    // Unused mode code keeps every gate off
    task automatic t_mode3();
        set_cfg(2'h3, 1'b0);
        host_u.put(6'h2a);
        settle();
        `CHECK(gates, 6'h00)
    endtask : t_mode3

    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        rst_n = 1'b0;
        mode_select = 2'h0;
        diode_freewheel = 1'b0;
        failures = 0;
        samples_checked = 0;
        rise_cnt = 0;
        a_hi_gate_d = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_six();
        t_dead();
        t_three();
        t_single(1'b0);
        t_single(1'b1);
        t_pwm();
        t_dwell();
        t_mode3();
        conclude();
    end

    // Run limit
    initial begin
        repeat (50000) @(posedge mclk);
        failures++;
        $display("ERROR t=%0t run limit reached", $time);
        conclude();
    end
endmodule : tpwm_decoder_bench

//--- tb/tpwm_host_model.sv
// Purpose: Host side model driving the six gate request pins.
// Assumes: Levels change just after a rising mclk edge.
// Notes: In single mode the A high pin carries the PWM.
`timescale 1ns/1ns
module tpwm_host_model (
    input wire logic mclk, // Logic clock
    output logic [5:0] pins // Packed request pins, package bit order
);
    // Idle levels from time zero
    initial begin
        pins = tpwm_pkg::IN_RST;
    end

    // Apply a full set of levels after the next edge
    task automatic put(input logic [5:0] v);
        @(posedge mclk);
        pins <= v;
    endtask : put

    // PWM on A high, index on the next four pins, C low last
    task automatic put_code(input logic [3:0] code, input logic pwm,
                            input logic c_lo);
        put({pwm, code, c_lo});
    endtask : put_code

    // Burst of PWM pulses on the A high pin only
    task automatic burst(input int n, input int on_c, input int off_c);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            pins[tpwm_pkg::IN_A_HI] <= 1'b1;
            repeat (on_c) @(posedge mclk);
            pins[tpwm_pkg::IN_A_HI] <= 1'b0;
            repeat (off_c - 1) @(posedge mclk);
        end
    endtask : burst
endmodule : tpwm_host_model
